/* verilog/ref_pulse_defs.svh */
// Offsets, fields, reset values and timing counts of the pulse decoder
`ifndef REF_PULSE_DEFS_SVH
`define REF_PULSE_DEFS_SVH

`define CLK_PERIOD_NS 5
`define FILT_TIME_NS 200
`define FILT_CYCLES ((`FILT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define OFS_CTRL 4'h0
`define OFS_GAIN 4'h4
`define OFS_POS 4'h8
`define OFS_STATUS 4'hc

`define CTRL_FORM_LSB 0
`define CTRL_FORM_MSB 3
`define CTRL_NOISE_BIT 4
`define FORM_LAST 4'h9
`define FORM_INV_FIRST 4'h5

`define GAIN_RESET 12'h258
`define GAIN_MIN 12'h096
`define GAIN_MAX 12'hbb8
`define RATED_SPEED_CODE 32'h00002000

`define STAT_SERVO_ON_BIT 0
`define STAT_CLEAR_BIT 1
`define STAT_PROP_BIT 2

`endif

/* verilog/ref_pulse_pkg.sv */
// Types shared by the pulse decoder files
`default_nettype none
package ref_pulse_pkg;
  typedef enum logic [2:0] {
    FORM_SIGN,
    FORM_UPDN,
    FORM_QX1,
    FORM_QX2,
    FORM_QX4
  } form_t;
  typedef logic signed [31:0] pos_t;
  typedef logic signed [1:0] step_t;
  typedef logic signed [23:0] speed_t;
endpackage
`default_nettype wire

/* verilog/line_filter.sv */
// Synchroniser and optional glitch filter for one reference line
`include "ref_pulse_defs.svh"
`default_nettype none
module line_filter #(
  parameter int FILT_LEN = `FILT_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Line
  input wire logic line_i,
  input wire logic filt_en_i,
  output logic line_o
);
  localparam int CW = $clog2(FILT_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT_LEN - 1);

  logic sync1_reg;
  logic sync2_reg;
  logic [CW-1:0] cnt_reg;

  // Two-flop synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= line_i;
      sync2_reg <= sync1_reg;
    end
  end

  // Level taken over once stable long enough
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      line_o <= 1'b0;
    end
    else if (sync2_reg == line_o)
      cnt_reg <= '0;
    else if (!filt_en_i || cnt_reg == LAST)
    begin
      line_o <= sync2_reg;
      cnt_reg <= '0;
    end
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

  filt_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (filt_en_i && $past(filt_en_i) && $changed(line_o)) |->
      $past(cnt_reg) == LAST)
    else $error("Filtered line changed before stable time");
endmodule
`default_nettype wire

/* verilog/reference_pulse_decoder.sv */
// Reference pulse decoder with position counter and Wishbone registers
//
// Implementation choices: the Wishbone slave port and the register offsets.
`include "ref_pulse_defs.svh"
`default_nettype none
// Behaviour
// - Software register selects how the two reference lines are read.
// - Form 0: each step pulse counts once, direction high forward.
// - Form 1: step line pulses count forward, direction line reverse.
// - Forms 2,3,4 are quadrature with x1, x2, x4 multipliers.
// - Quadrature: B leading A is forward, A leading B reverse.
// - Position count follows the net decoded increments.
// - Proportional input asserted makes speed loop proportional-only.
// - Gain 150 to 3000 in 0.01 V scales speed reference, 600 default.
// - Noise option adds an input glitch filter.
module reference_pulse_decoder (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Reference lines
  input wire logic step_train_in_i,
  input wire logic step_train_in_n_i,
  input wire logic dir_code_in_i,
  input wire logic dir_code_in_n_i,
  input wire logic servo_on_i,
  input wire logic count_reset_in_i,
  input wire logic prop_only_in_n_i,
  // Speed reference
  input wire logic signed [15:0] speed_ref_i,
  output ref_pulse_pkg::speed_t speed_cmd_o,
  output logic prop_only_o,
  // Position
  output ref_pulse_pkg::pos_t pos_count_o,
  output ref_pulse_pkg::step_t pos_step_o
);
  import ref_pulse_pkg::*;

  logic [3:0] form_sel_reg;
  logic noise_reg;
  logic [11:0] gain_reg;
  logic ack_reg;
  logic a_lvl;
  logic b_lvl;
  logic a_prev_reg;
  logic b_prev_reg;
  logic armed_reg;
  logic inv;
  form_t form;
  logic a_c;
  logic b_c;
  logic a_p;
  logic b_p;
  step_t inc;
  pos_t pos_reg;
  step_t step_reg;
  logic signed [31:0] prod;
  logic signed [31:0] quot;
  logic wr;
  logic [31:0] rd_next;

  // Bus access strobes
  assign wr = cyc_i && stb_i && we_i && ack_reg;
  assign ack_o = ack_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= cyc_i && stb_i && !ack_reg;
  end

  // Control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      form_sel_reg <= 4'h0;
      noise_reg <= 1'b0;
    end
    else if (wr && sel_i[0] && adr_i == `OFS_CTRL)
    begin
      if (dat_i[`CTRL_FORM_MSB:`CTRL_FORM_LSB] <= `FORM_LAST)
        form_sel_reg <= dat_i[`CTRL_FORM_MSB:`CTRL_FORM_LSB];
      noise_reg <= dat_i[`CTRL_NOISE_BIT];
    end
  end

  // Gain register, out-of-range writes ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gain_reg <= `GAIN_RESET;
    else if (wr && sel_i[1:0] == 2'b11 && adr_i == `OFS_GAIN)
    begin
      if (dat_i[31:12] == 20'h00000 && dat_i[11:0] >= `GAIN_MIN &&
          dat_i[11:0] <= `GAIN_MAX)
        gain_reg <= dat_i[11:0];
    end
  end

  // Read data
  always_comb
  begin
    rd_next = 32'h00000000;
    if (adr_i == `OFS_CTRL)
      rd_next = {27'h0000000, noise_reg, form_sel_reg};
    else if (adr_i == `OFS_GAIN)
      rd_next = {20'h00000, gain_reg};
    else if (adr_i == `OFS_POS)
      rd_next = pos_reg;
    else if (adr_i == `OFS_STATUS)
      rd_next = {29'h00000000, prop_only_o, count_reset_in_i, servo_on_i};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h00000000;
    else if (cyc_i && stb_i && !ack_reg)
      dat_o <= rd_next;
  end

  // Line conditioning
  for (genvar i = 0; i < 2; i++)
  begin : g_line
    logic raw;
    logic lvl;
    assign raw = (i == 0) ? (step_train_in_i && !step_train_in_n_i)
                          : (dir_code_in_i && !dir_code_in_n_i);
    line_filter #(.FILT_LEN(`FILT_CYCLES)) u_filt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .line_i(raw),
      .filt_en_i(noise_reg),
      .line_o(lvl)
    );
  end
  assign a_lvl = g_line[0].lvl;
  assign b_lvl = g_line[1].lvl;

  // Previous levels for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      armed_reg <= 1'b0;
    end
    else
    begin
      a_prev_reg <= a_lvl;
      b_prev_reg <= b_lvl;
      armed_reg <= 1'b1;
    end
  end

  // Form and polarity
  always_comb
  begin
    inv = form_sel_reg >= `FORM_INV_FIRST;
    case (inv ? form_sel_reg - `FORM_INV_FIRST : form_sel_reg)
      4'h1: form = FORM_UPDN;
      4'h2: form = FORM_QX1;
      4'h3: form = FORM_QX2;
      4'h4: form = FORM_QX4;
      default: form = FORM_SIGN;
    endcase
  end

  assign a_c = a_lvl ^ inv;
  assign b_c = b_lvl ^ inv;
  assign a_p = a_prev_reg ^ inv;
  assign b_p = b_prev_reg ^ inv;

  // Increment decode
  always_comb
  begin
    inc = 2'sb00;
    case (form)
      FORM_SIGN:
        if (a_c && !a_p)
          inc = b_c ? 2'sb01 : 2'sb11;
      FORM_UPDN:
        if (a_c && !a_p && !(b_c && !b_p))
          inc = 2'sb01;
        else if (b_c && !b_p && !(a_c && !a_p))
          inc = 2'sb11;
      FORM_QX1:
        if (a_c && !a_p)
          inc = b_c ? 2'sb01 : 2'sb11;
      FORM_QX2:
        if (a_c != a_p && b_c == b_p)
          inc = (a_c == b_c) ? 2'sb01 : 2'sb11;
      FORM_QX4:
        if ((a_c ^ a_p) ^ (b_c ^ b_p))
          inc = (a_p ^ b_c) ? 2'sb01 : 2'sb11;
      default:
        inc = 2'sb00;
    endcase
    if (!armed_reg || !servo_on_i || count_reset_in_i)
      inc = 2'sb00;
  end

  // Position counter, held clear while reset input is high
  always_ff @(posedge clk_i)
  begin
    if (rst_i || count_reset_in_i)
    begin
      pos_reg <= '0;
      step_reg <= 2'sb00;
    end
    else
    begin
      pos_reg <= pos_reg + 32'(inc);
      step_reg <= inc;
    end
  end
  assign pos_count_o = pos_reg;
  assign pos_step_o = step_reg;

  // Speed loop mode and scaled speed command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prop_only_o <= 1'b0;
    else
      prop_only_o <= !prop_only_in_n_i;
  end

  assign prod = 32'(speed_ref_i) * $signed(`RATED_SPEED_CODE);
  assign quot = prod / $signed({20'h00000, gain_reg});

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      speed_cmd_o <= '0;
    else
      speed_cmd_o <= quot[23:0];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bus_ack_a: assert property (
    (cyc_i && stb_i && !ack_reg) |=> ack_reg ##1 !ack_reg)
    else $error("Bus ack not one cycle after request");
  sign_dir_a: assert property (
    (form == FORM_SIGN && a_c && !a_p && armed_reg && servo_on_i &&
     !count_reset_in_i) |=> pos_step_o == ($past(b_c) ? 2'sb01 : 2'sb11))
    else $error("Sign form direction wrong");
  updn_rev_a: assert property (
    (form == FORM_UPDN && b_c && !b_p && a_c == a_p && armed_reg &&
     servo_on_i && !count_reset_in_i) |=> pos_step_o == 2'sb11)
    else $error("Reverse line did not count down");
  qx1_fall_a: assert property (
    (form == FORM_QX1 && !a_c && a_p) |=> pos_step_o == 2'sb00)
    else $error("x1 counted a falling edge");
  quad_fwd_a: assert property (
    (form == FORM_QX4 && a_p && !b_p && !a_c && !b_c && armed_reg &&
     servo_on_i && !count_reset_in_i) |=> pos_step_o == 2'sb01)
    else $error("B leading A not forward");
  invert_a: assert property (
    (form_sel_reg >= `FORM_INV_FIRST) |-> (a_c == !a_lvl && b_c == !b_lvl))
    else $error("Inverted form not inverting");
  pos_track_a: assert property (
    (!count_reset_in_i) |=>
      pos_count_o == $past(pos_count_o) + 32'($past(inc)))
    else $error("Position count lost an increment");
  prop_mode_a: assert property (
    (!prop_only_in_n_i) [*2] |-> prop_only_o)
    else $error("Proportional mode not entered");
  gain_range_a: assert property (
    gain_reg >= `GAIN_MIN && gain_reg <= `GAIN_MAX)
    else $error("Gain out of range");
  edge_once_a: assert property (
    (pos_step_o != 2'sb00 && form == FORM_SIGN && $stable(form_sel_reg))
      |=> pos_step_o == 2'sb00)
    else $error("Sign edge counted twice");

  cov_sign_c: cover property (form == FORM_SIGN && pos_step_o == 2'sb01);
  cov_qx4_rev_c: cover property (form == FORM_QX4 && pos_step_o == 2'sb11);
  cov_inv_c: cover property (inv && pos_step_o != 2'sb00);
  cov_clear_c: cover property (count_reset_in_i && $past(pos_reg) != 0);
endmodule
`default_nettype wire

/* verif/ref_host_model.sv */
// Host controller model driving the differential reference lines
`default_nettype none
module ref_host_model (
  // Clock
  input wire logic clk_i,
  // Differential step and direction lines
  output logic step_p_o,
  output logic step_n_o,
  output logic dir_p_o,
  output logic dir_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic inv = 1'b0;
  int hold = 3;
  initial
  begin
    step_p_o = 1'b0;
    step_n_o = 1'b1;
    dir_p_o = 1'b0;
    dir_n_o = 1'b1;
  end
  // Drive logical levels, inverted for negative-logic forms
  task automatic put(input logic a, input logic b);
    @(posedge clk_i);
    step_p_o <= a ^ inv;
    step_n_o <= ~(a ^ inv);
    dir_p_o <= b ^ inv;
    dir_n_o <= ~(b ^ inv);
    repeat (hold) @(posedge clk_i);
  endtask
  // One forward or reverse unit of the chosen pulse form
  task automatic unit(input int base, input logic fwd);
    if (base == 0)
    begin
      put(1'b0, fwd);
      put(1'b1, fwd);
      put(1'b0, fwd);
    end
    else if (base == 1)
    begin
      put(fwd, ~fwd);
      put(1'b0, 1'b0);
    end
    else
    begin
      put(~fwd, fwd);
      put(1'b1, 1'b1);
      put(fwd, ~fwd);
      put(1'b0, 1'b0);
    end
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the reference pulse decoder
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic servo = 1'b0;
  logic count_rst = 1'b0;
  logic prop_n = 1'b1;
  logic signed [15:0] speed_ref = 16'sh0;
  ref_pulse_pkg::speed_t speed_cmd;
  logic prop_only;
  logic step_p, step_n, dir_p, dir_n;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  localparam int SERVO_WAIT = 2000;
  ref_pulse_pkg::pos_t pos_count;
  ref_pulse_pkg::step_t pos_step;
  int step_sum = 0;
  logic [31:0] mult [5] = '{32'h1, 32'h1, 32'h1, 32'h2, 32'h4};
  always #2.5 clk = ~clk;
  reference_pulse_decoder dut_u (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .step_train_in_i(step_p), .step_train_in_n_i(step_n),
    .dir_code_in_i(dir_p), .dir_code_in_n_i(dir_n),
    .servo_on_i(servo), .count_reset_in_i(count_rst),
    .prop_only_in_n_i(prop_n), .speed_ref_i(speed_ref),
    .speed_cmd_o(speed_cmd), .prop_only_o(prop_only),
    .pos_count_o(pos_count), .pos_step_o(pos_step)
  );
  ref_host_model host_u (
    .clk_i(clk), .step_p_o(step_p), .step_n_o(step_n),
    .dir_p_o(dir_p), .dir_n_o(dir_n)
  );
  task automatic summarize();
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      miscompares++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // Clear the count while the form and line polarity change
  task automatic prep(input logic [31:0] ctrl, input logic inv);
    count_rst <= 1'b1;
    host_u.inv = inv;
    host_u.put(1'b0, 1'b0);
    wr(4'h0, ctrl);
    repeat (4000) @(posedge clk);
    count_rst <= 1'b0;
    @(posedge clk);
    rd(4'h8, 32'h0);
  endtask
  // Net of the one-cycle step pulses since the last count reset
  always @(posedge clk)
  begin
    if (count_rst)
      step_sum <= 0;
    else
      step_sum <= step_sum + int'(pos_step);
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 70000)
    begin
      miscompares++;
      summarize();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    servo <= 1'b1;
    // Settling wait after servo-on, shortened to fit the run
    repeat (SERVO_WAIT) @(posedge clk);
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h258);
    rd(4'h2, 32'h0);
    speed_ref <= 16'sd600;
    repeat (2) @(posedge clk);
    chk(32'(speed_cmd), 32'h2000);
    wr(4'h4, 32'h12c);
    wr(4'h4, 32'h64);
    rd(4'h4, 32'h12c);
    chk(32'(speed_cmd), 32'h4000);
    speed_ref <= -16'sd300;
    repeat (2) @(posedge clk);
    chk(32'(speed_cmd), 32'hffffe000);
    prop_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, prop_only}, 32'h1);
    rd(4'hc, 32'h5);
    prop_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, prop_only}, 32'h0);
    for (int f = 0; f < 10; f++)
    begin
      prep(32'(f), f >= 5);
      rd(4'h0, 32'(f));
      host_u.unit(f % 5, 1'b1);
      host_u.unit(f % 5, 1'b1);
      host_u.unit(f % 5, 1'b0);
      repeat (8) @(posedge clk);
      rd(4'h8, mult[f % 5]);
      chk(pos_count, mult[f % 5]);
      chk(step_sum, mult[f % 5]);
    end
    wr(4'h0, 32'h1f);
    rd(4'h0, 32'h19);
    prep(32'h11, 1'b0);
    host_u.put(1'b1, 1'b0);
    host_u.put(1'b0, 1'b0);
    host_u.hold = 50;
    host_u.put(1'b1, 1'b0);
    host_u.put(1'b0, 1'b0);
    repeat (60) @(posedge clk);
    rd(4'h8, 32'h1);
    chk(step_sum, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
